// ==== design/uncore_home_event_pkg.sv ====
// shared constants, types and carriers for the uncore home event counter
`default_nettype none

package uncore_home_event_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses on the AHB-Lite slave)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00; // enable bit
	localparam logic [7:0] ADDR_SELECT = 8'h04; // event code, unit mask, state filter
	localparam logic [7:0] ADDR_COUNT_LO = 8'h08; // counter bits 31:0
	localparam logic [7:0] ADDR_COUNT_HI = 8'h0c; // counter bits 47:32
	localparam logic [7:0] ADDR_STATUS = 8'h10; // read-only block state

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CONTROL_ENABLE_BIT = 0; // counting enable
	localparam int SELECT_CODE_LSB = 0; // event code byte
	localparam int SELECT_UMASK_LSB = 8; // unit mask byte
	localparam int SELECT_FILTER_LSB = 16; // state filter nibble
	localparam int STATUS_MATCH_BIT = 0; // selection is a defined one
	localparam int STATUS_ACTIVE_LSB = 8; // live conflict table entries

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic CONTROL_RESET = 1'b0;
	localparam logic [7:0] CODE_RESET = 8'h00;
	localparam logic [7:0] UMASK_RESET = 8'h00;
	localparam logic [3:0] FILTER_RESET = 4'h0;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int COUNT_W = 48; // event counter width
	localparam int COUNT_HI_W = 16; // upper counter word width
	localparam int TRACKERS = 3; // io hub, remote, local
	localparam int OCC_W = 6; // tracker read occupancy width
	localparam int CT_DEPTH = 8; // conflict table entries
	localparam int CT_IDX_W = 3; // conflict table index width
	localparam int CT_CNT_W = 2; // per-entry conflict tally width
	localparam int CT_ACTIVE_W = 4; // live entry count width

	// ------------------------------------------------------------
	// unit masks and state filter values
	// ------------------------------------------------------------
	localparam logic [7:0] UMASK_INVALIDATE = 8'h08; // snoop demotes to invalid
	localparam logic [7:0] UMASK_IO_HUB = 8'h01; // io hub tracker
	localparam logic [7:0] UMASK_REMOTE = 8'h02; // remote tracker
	localparam logic [7:0] UMASK_LOCAL = 8'h04; // local tracker
	localparam logic [7:0] UMASK_TWO_WAY = 8'h02; // at most two conflicts
	localparam logic [1:0] TWO_WAY_LIMIT = 2'h2; // conflict ceiling for the tally
	localparam logic [3:0] FILTER_MODIFIED = 4'h1; // prior state modified
	localparam logic [3:0] FILTER_SHARED = 4'h4; // prior state shared
	localparam logic [3:0] FILTER_FORWARD = 4'h8; // prior state forward
	localparam int TRK_IO_HUB = 0; // tracker index of io hub
	localparam int TRK_REMOTE = 1; // tracker index of remote socket
	localparam int TRK_LOCAL = 2; // tracker index of local socket

	// ------------------------------------------------------------
	// event codes
	// ------------------------------------------------------------
	typedef enum logic [7:0] {
		REMOTE_SNOOP_DEMOTE_EVENT = 8'h0c,
		HOME_REQUEST_COUNT_EVENT = 8'h20,
		TRACKER_FULL_CYCLES_EVENT = 8'h21,
		TRACKER_BUSY_CYCLES_EVENT = 8'h22,
		TRACKER_READ_OCCUPANCY_EVENT = 8'h23,
		CONFLICT_TABLE_TALLY_EVENT = 8'h24
	} evt_code_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid; // one remote snoop this cycle
		logic toInvalid; // snoop demands invalid state
		logic [3:0] priorState; // one-hot: 1 M, 2 E, 4 S, 8 F
	} snoop_s;

	typedef struct packed {
		logic [TRACKERS-1:0] read; // read request per source
		logic [TRACKERS-1:0] write; // write request per source
	} home_req_s;

	typedef struct packed {
		logic full; // every entry occupied
		logic busy; // at least one entry occupied
		logic [OCC_W-1:0] readOccupancy; // read entries held this cycle
	} tracker_s;

	typedef struct packed {
		logic allocValid; // open an entry for a conflicting request
		logic [CT_IDX_W-1:0] allocIndex; // entry to open
		logic [OCC_W-1:0] allocSlot; // home tracker slot that holds the request
		logic conflictValid; // one more conflict on an entry
		logic [CT_IDX_W-1:0] conflictIndex; // entry that saw it
		logic deallocValid; // close an entry
		logic [CT_IDX_W-1:0] deallocIndex; // entry to close
	} conflict_op_s;

endpackage : uncore_home_event_pkg

`default_nettype wire

// ==== design/active_conflict_table.sv ====
// conflict table: pointers to conflicting home tracker slots with tallies
`default_nettype none

module active_conflict_table (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// table operations
	input wire uncore_home_event_pkg::conflict_op_s op,
	// tally reported on deallocation
	output logic tallyValid,
	output logic [uncore_home_event_pkg::CT_CNT_W-1:0] tallyCount,
	// live entry count
	output logic [uncore_home_event_pkg::CT_ACTIVE_W-1:0] activeCount
);

	// ------------------------------------------------------------
	// entry storage
	// ------------------------------------------------------------
	logic [uncore_home_event_pkg::CT_DEPTH-1:0] valid_q, valid_d; // entry in use
	logic [uncore_home_event_pkg::CT_CNT_W-1:0] count_q [uncore_home_event_pkg::CT_DEPTH]; // conflicts seen
	logic [uncore_home_event_pkg::CT_CNT_W-1:0] count_d [uncore_home_event_pkg::CT_DEPTH];
	logic [uncore_home_event_pkg::OCC_W-1:0] slot_q [uncore_home_event_pkg::CT_DEPTH]; // tracker slot pointer
	logic [uncore_home_event_pkg::OCC_W-1:0] slot_d [uncore_home_event_pkg::CT_DEPTH];
	logic tallyValid_q, tallyValid_d;
	logic [uncore_home_event_pkg::CT_CNT_W-1:0] tallyCount_q, tallyCount_d;
	logic [uncore_home_event_pkg::CT_ACTIVE_W-1:0] active_q, active_d;

	// ------------------------------------------------------------
	// per-entry next state
	// ------------------------------------------------------------
	genvar e;
	generate
		for (e = 0; e < uncore_home_event_pkg::CT_DEPTH; e++) begin : gEntry
			// only the slot pointer is kept, the request stays in the tracker
			always_comb begin
				valid_d[e] = valid_q[e];
				count_d[e] = count_q[e];
				slot_d[e] = slot_q[e];
				if (op.deallocValid && op.deallocIndex == 3'(e)) begin
					// close the entry
					valid_d[e] = 1'b0;
				end else if (op.allocValid && op.allocIndex == 3'(e)) begin
					// an entry opens on its first conflict
					valid_d[e] = 1'b1;
					count_d[e] = 2'h1;
					slot_d[e] = op.allocSlot;
				end else if (op.conflictValid && op.conflictIndex == 3'(e) && valid_q[e] && count_q[e] != 2'h3) begin
					// saturating tally of further conflicts
					count_d[e] = count_q[e] + 2'h1;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// report and live count
	// ------------------------------------------------------------
	always_comb begin
		// the tally leaves only when the entry deallocates
		tallyValid_d = op.deallocValid && valid_q[op.deallocIndex];
		tallyCount_d = count_q[op.deallocIndex];
		active_d = '0;
		for (int i = 0; i < uncore_home_event_pkg::CT_DEPTH; i++) begin
			active_d = active_d + {3'h0, valid_d[i]};
		end
	end

	// registers only
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			valid_q <= '0;
			tallyValid_q <= 1'b0;
			tallyCount_q <= '0;
			active_q <= '0;
			for (int i = 0; i < uncore_home_event_pkg::CT_DEPTH; i++) begin
				count_q[i] <= '0;
				slot_q[i] <= '0;
			end
		end else begin
			valid_q <= valid_d;
			tallyValid_q <= tallyValid_d;
			tallyCount_q <= tallyCount_d;
			active_q <= active_d;
			for (int i = 0; i < uncore_home_event_pkg::CT_DEPTH; i++) begin
				count_q[i] <= count_d[i];
				slot_q[i] <= slot_d[i];
			end
		end
	end

	assign tallyValid = tallyValid_q;
	assign tallyCount = tallyCount_q;
	assign activeCount = active_q;

endmodule : active_conflict_table

`default_nettype wire

// ==== design/uncore_home_event_counter.sv ====
// uncore home event counter with event selection and AHB-Lite registers
//
// Local design decisions: the placing of the registers and the AHB-Lite interface to the registers.
`default_nettype none

// What this block does
// - filter 8H counts snoops invalidating forward lines
// - filter 1H counts snoops invalidating modified lines
// - filter 4H counts snoops invalidating shared lines
// - code 20H counts io hub reads, writes
// - code 20H counts remote socket reads, writes
// - code 20H counts local socket reads, writes
// - code 21H adds cycles chosen tracker full
// - code 22H adds cycles chosen tracker busy
// - code 23H sums held read entries per cycle
// - code 24H counts entries with at most two conflicts
// - tally added only when entry deallocates
// - conflict table holds pointers, tracker holds requests
module uncore_home_event_counter (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// uncore event sources
	input wire uncore_home_event_pkg::snoop_s snoop,
	input wire uncore_home_event_pkg::home_req_s homeReq,
	input wire uncore_home_event_pkg::tracker_s [uncore_home_event_pkg::TRACKERS-1:0] tracker,
	input wire uncore_home_event_pkg::conflict_op_s conflictOp
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic enable_q, enable_d; // counting enable
	logic [7:0] code_q, code_d; // selected event code
	logic [7:0] umask_q, umask_d; // selected unit mask
	logic [3:0] filter_q, filter_d; // snoop state filter
	logic [uncore_home_event_pkg::COUNT_W-1:0] count_q, count_d; // the event counter
	logic match_q, match_d; // selection is defined
	logic [31:0] rdata_q, rdata_d; // read data for the data phase
	logic ready_q; // hreadyout flop
	logic resp_q; // hresp flop
	logic wrPend_q, wrPend_d; // write data phase pending
	logic [7:0] wrAddr_q, wrAddr_d; // address of pending write
	logic addrPhase; // valid transfer in address phase
	logic [7:0] busAddr; // word-aligned low address
	logic [uncore_home_event_pkg::OCC_W-1:0] incr; // amount added this cycle
	logic defined; // combination is known
	logic [uncore_home_event_pkg::TRACKERS-1:0] fullVec; // full per tracker
	logic [uncore_home_event_pkg::TRACKERS-1:0] busyVec; // busy per tracker
	logic [uncore_home_event_pkg::OCC_W-1:0] occArr [uncore_home_event_pkg::TRACKERS]; // occupancy per tracker
	logic [5:0] reqVec; // request pulses in unit mask order
	logic [1:0] trkIdx; // tracker chosen by unit mask
	logic trkValid; // unit mask picks exactly one tracker
	logic tallyValid; // conflict entry just closed
	logic [uncore_home_event_pkg::CT_CNT_W-1:0] tallyCount; // its conflict tally
	logic [uncore_home_event_pkg::CT_ACTIVE_W-1:0] activeCount; // live entries

	// ------------------------------------------------------------
	// conflict table
	// ------------------------------------------------------------
	active_conflict_table uConflictTable (
		.clk_sys(clk_sys),
		.reset(reset),
		.op(conflictOp),
		.tallyValid(tallyValid),
		.tallyCount(tallyCount),
		.activeCount(activeCount)
	);

	// ------------------------------------------------------------
	// per-tracker condition vectors
	// ------------------------------------------------------------
	genvar t;
	generate
		for (t = 0; t < uncore_home_event_pkg::TRACKERS; t++) begin : gTracker
			// split the tracker carrier into per-kind vectors
			assign fullVec[t] = tracker[t].full;
			assign busyVec[t] = tracker[t].busy;
			assign occArr[t] = tracker[t].readOccupancy;
		end
	endgenerate

	// request pulses ordered as unit mask bits 0 to 5
	assign reqVec = {homeReq.write[uncore_home_event_pkg::TRK_LOCAL], homeReq.read[uncore_home_event_pkg::TRK_LOCAL],
		homeReq.write[uncore_home_event_pkg::TRK_REMOTE], homeReq.read[uncore_home_event_pkg::TRK_REMOTE],
		homeReq.write[uncore_home_event_pkg::TRK_IO_HUB], homeReq.read[uncore_home_event_pkg::TRK_IO_HUB]};

	// ------------------------------------------------------------
	// tracker choice from the unit mask
	// ------------------------------------------------------------
	always_comb begin
		trkIdx = 2'h0;
		trkValid = 1'b1;
		case (umask_q)
			// io hub tracker
			uncore_home_event_pkg::UMASK_IO_HUB: begin
				trkIdx = 2'(uncore_home_event_pkg::TRK_IO_HUB);
			end
			// remote tracker
			uncore_home_event_pkg::UMASK_REMOTE: begin
				trkIdx = 2'(uncore_home_event_pkg::TRK_REMOTE);
			end
			// local tracker
			uncore_home_event_pkg::UMASK_LOCAL: begin
				trkIdx = 2'(uncore_home_event_pkg::TRK_LOCAL);
			end
			// anything else names no tracker
			default: begin
				trkValid = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// event selection and increment
	// ------------------------------------------------------------
	always_comb begin
		incr = '0;
		defined = 1'b0;
		case (code_q)
			// remote snoops demoting a line to invalid
			uncore_home_event_pkg::REMOTE_SNOOP_DEMOTE_EVENT: begin
				if (umask_q == uncore_home_event_pkg::UMASK_INVALIDATE &&
					(filter_q == uncore_home_event_pkg::FILTER_FORWARD ||
					filter_q == uncore_home_event_pkg::FILTER_MODIFIED ||
					filter_q == uncore_home_event_pkg::FILTER_SHARED)) begin
					defined = 1'b1;
					// prior state must match the programmed filter
					if (snoop.valid && snoop.toInvalid && (snoop.priorState & filter_q) != 4'h0) begin
						incr = 6'h01;
					end
				end
			end
			// home requests by source and direction
			uncore_home_event_pkg::HOME_REQUEST_COUNT_EVENT: begin
				if (umask_q[7:6] == 2'h0 && $onehot(umask_q[5:0])) begin
					defined = 1'b1;
					// one selected source and direction per unit mask bit
					if ((umask_q[5:0] & reqVec) != 6'h00) begin
						incr = 6'h01;
					end
				end
			end
			// cycles with every entry occupied
			uncore_home_event_pkg::TRACKER_FULL_CYCLES_EVENT: begin
				defined = trkValid;
				if (trkValid && fullVec[trkIdx]) begin
					incr = 6'h01;
				end
			end
			// cycles with the tracker busy
			uncore_home_event_pkg::TRACKER_BUSY_CYCLES_EVENT: begin
				defined = trkValid;
				if (trkValid && busyVec[trkIdx]) begin
					incr = 6'h01;
				end
			end
			// read entries held, summed every cycle
			uncore_home_event_pkg::TRACKER_READ_OCCUPANCY_EVENT: begin
				defined = trkValid;
				if (trkValid) begin
					incr = occArr[trkIdx];
				end
			end
			// conflict table entries closing with a small tally
			uncore_home_event_pkg::CONFLICT_TABLE_TALLY_EVENT: begin
				if (umask_q == uncore_home_event_pkg::UMASK_TWO_WAY) begin
					defined = 1'b1;
					// counted on the close pulse only
					if (tallyValid && tallyCount <= uncore_home_event_pkg::TWO_WAY_LIMIT) begin
						incr = 6'h01;
					end
				end
			end
			// unknown code adds nothing
			default: begin
				incr = '0;
			end
		endcase
		if (!defined) begin
			incr = '0;
		end
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign addrPhase = hsel && hready && htrans[1];
	assign busAddr = {haddr[7:2], 2'b00};

	// ------------------------------------------------------------
	// register and counter next values
	// ------------------------------------------------------------
	always_comb begin
		enable_d = enable_q;
		code_d = code_q;
		umask_d = umask_q;
		filter_d = filter_q;
		rdata_d = rdata_q;
		wrPend_d = 1'b0;
		wrAddr_d = wrAddr_q;
		match_d = defined;
		// counting runs when enabled
		count_d = count_q;
		if (enable_q) begin
			count_d = count_q + {{(uncore_home_event_pkg::COUNT_W-uncore_home_event_pkg::OCC_W){1'b0}}, incr};
		end
		// write data phase: a software write wins over counting
		if (wrPend_q) begin
			case (wrAddr_q)
				// enable bit
				uncore_home_event_pkg::ADDR_CONTROL: begin
					enable_d = hwdata[uncore_home_event_pkg::CONTROL_ENABLE_BIT];
				end
				// event selection
				uncore_home_event_pkg::ADDR_SELECT: begin
					code_d = hwdata[uncore_home_event_pkg::SELECT_CODE_LSB +: 8];
					umask_d = hwdata[uncore_home_event_pkg::SELECT_UMASK_LSB +: 8];
					filter_d = hwdata[uncore_home_event_pkg::SELECT_FILTER_LSB +: 4];
				end
				// preload low counter word
				uncore_home_event_pkg::ADDR_COUNT_LO: begin
					count_d = {count_q[uncore_home_event_pkg::COUNT_W-1:32], hwdata};
				end
				// preload high counter word
				uncore_home_event_pkg::ADDR_COUNT_HI: begin
					count_d = {hwdata[uncore_home_event_pkg::COUNT_HI_W-1:0], count_q[31:0]};
				end
				// status and unmapped writes are dropped
				default: begin
					count_d = count_d;
				end
			endcase
		end
		// address phase: latch writes, fetch read data
		if (addrPhase) begin
			if (hwrite) begin
				wrPend_d = 1'b1;
				wrAddr_d = busAddr;
			end else begin
				case (busAddr)
					// enable bit
					uncore_home_event_pkg::ADDR_CONTROL: begin
						rdata_d = {31'h0, enable_q};
					end
					// event selection
					uncore_home_event_pkg::ADDR_SELECT: begin
						rdata_d = {12'h000, filter_q, umask_q, code_q};
					end
					// low counter word
					uncore_home_event_pkg::ADDR_COUNT_LO: begin
						rdata_d = count_q[31:0];
					end
					// high counter word
					uncore_home_event_pkg::ADDR_COUNT_HI: begin
						rdata_d = {16'h0000, count_q[uncore_home_event_pkg::COUNT_W-1:32]};
					end
					// selection validity and conflict table fill
					uncore_home_event_pkg::ADDR_STATUS: begin
						rdata_d = {20'h00000, activeCount, 7'h00, match_q};
					end
					// unmapped reads return zero
					default: begin
						rdata_d = 32'h00000000;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// registers only
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			enable_q <= uncore_home_event_pkg::CONTROL_RESET;
			code_q <= uncore_home_event_pkg::CODE_RESET;
			umask_q <= uncore_home_event_pkg::UMASK_RESET;
			filter_q <= uncore_home_event_pkg::FILTER_RESET;
			count_q <= '0;
			match_q <= 1'b0;
			rdata_q <= 32'h00000000;
			ready_q <= 1'b1;
			resp_q <= 1'b0;
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			enable_q <= enable_d;
			code_q <= code_d;
			umask_q <= umask_d;
			filter_q <= filter_d;
			count_q <= count_d;
			match_q <= match_d;
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
			resp_q <= 1'b0;
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign hrdata = rdata_q;
	assign hreadyout = ready_q;
	assign hresp = resp_q;

endmodule : uncore_home_event_counter

`default_nettype wire

// ==== testbench/uncore_home_event_counter_properties.sv ====
// port checker for the uncore home event counter
`default_nettype none

module uncore_home_event_counter_properties (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic take; // address phase accepted
	logic [5:0] idx; // word index
	assign take = hsel && hready && htrans[1];
	assign idx = haddr[7:2];
	// ------------------------------------------------------------
	// register transfer steps
	// ------------------------------------------------------------
	sequence selWr; take && hwrite && idx == 6'h01; endsequence
	sequence selRd; take && !hwrite && idx == 6'h01; endsequence
	sequence ctlWr; take && hwrite && idx == 6'h00; endsequence
	sequence ctlRd; take && !hwrite && idx == 6'h00; endsequence
	a_ready_high: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp not okay");
	a_rdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata)) else $error("hrdata moved");
	a_unmapped_zero: assert property (take && !hwrite && idx > 6'h04 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_hi_width: assert property (take && !hwrite && idx == 6'h03 |=> hrdata[31:16] == 16'h0)
		else $error("upper count word too wide");
	a_status_width: assert property (take && !hwrite && idx == 6'h04 |=> hrdata[31:12] == 20'h0 && hrdata[7:1] == 7'h0)
		else $error("status spare bits set");
	a_select_echo: assert property (selWr ##2 selRd |=> hrdata == {12'h0, $past(hwdata[19:0], 2)})
		else $error("select readback wrong");
	a_control_echo: assert property (ctlWr ##2 ctlRd |=> hrdata == {31'h0, $past(hwdata[0], 2)})
		else $error("control readback wrong");
endmodule : uncore_home_event_counter_properties

`default_nettype wire

// ==== testbench/tb_uncore_home_event_counter.sv ====
// self-checking bench for the uncore home event counter
`default_nettype none

module tb_uncore_home_event_counter;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	uncore_home_event_pkg::snoop_s snoop = '0;
	uncore_home_event_pkg::home_req_s homeReq = '0;
	uncore_home_event_pkg::tracker_s [2:0] tracker = '0;
	uncore_home_event_pkg::conflict_op_s conflictOp = '0;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	logic [31:0] rd; // last read data
	uncore_home_event_counter u_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .snoop(snoop), .homeReq(homeReq), .tracker(tracker),
		.conflictOp(conflictOp));
	initial forever #5 clk_sys = ~clk_sys;
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic waitReady();
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
	endtask : waitReady
	// one single word transfer, read data left in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		rd = hrdata;
	endtask : bus
	task automatic idle();
		snoop <= '0;
		homeReq <= '0;
		tracker <= '0;
		conflictOp <= '0;
		@(posedge clk_sys);
	endtask : idle
	// select an event, clear the count, start counting
	task automatic arm(input logic [7:0] code, input logic [7:0] um, input logic [3:0] f);
		bus(1'b1, uncore_home_event_pkg::ADDR_CONTROL, 32'h0);
		bus(1'b1, uncore_home_event_pkg::ADDR_SELECT, {12'h0, f, um, code});
		bus(1'b1, uncore_home_event_pkg::ADDR_COUNT_LO, 32'h0);
		bus(1'b1, uncore_home_event_pkg::ADDR_COUNT_HI, 32'h0);
		bus(1'b1, uncore_home_event_pkg::ADDR_CONTROL, 32'h1);
	endtask : arm
	// let late tallies land, stop, read the count
	task automatic expectCount(input logic [31:0] exp);
		repeat (3) @(posedge clk_sys);
		bus(1'b1, uncore_home_event_pkg::ADDR_CONTROL, 32'h0);
		bus(1'b0, uncore_home_event_pkg::ADDR_COUNT_LO, 32'h0);
		chk(rd, exp);
	endtask : expectCount
	task automatic testRegs();
		bus(1'b0, uncore_home_event_pkg::ADDR_SELECT, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, uncore_home_event_pkg::ADDR_COUNT_HI, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, uncore_home_event_pkg::ADDR_SELECT, 32'hffffffff);
		bus(1'b0, uncore_home_event_pkg::ADDR_SELECT, 32'h0);
		chk(rd, 32'h000fffff);
		bus(1'b1, uncore_home_event_pkg::ADDR_CONTROL, 32'hffffffff);
		bus(1'b0, uncore_home_event_pkg::ADDR_CONTROL, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, uncore_home_event_pkg::ADDR_STATUS, 32'hffffffff);
		bus(1'b0, uncore_home_event_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
	endtask : testRegs
	task automatic testSnoop();
		logic [3:0] fs [3] = '{4'h1, 4'h4, 4'h8};
		foreach (fs[i]) begin
			arm(8'h0c, 8'h08, fs[i]);
			snoop <= {2'h3, fs[i]};
			repeat (3) @(posedge clk_sys);
			snoop <= {2'h2, fs[i]}; // demote to shared only
			@(posedge clk_sys);
			snoop <= {2'h3, 4'h2}; // exclusive prior state
			@(posedge clk_sys);
			snoop <= {2'h1, fs[i]}; // no snoop this cycle
			@(posedge clk_sys);
			idle();
			expectCount(32'h3);
		end
	endtask : testSnoop
	task automatic testRequests();
		logic [2:0] s;
		for (int i = 0; i < 6; i++) begin
			s = 3'h1 << (i / 2);
			arm(8'h20, 8'h01 << i, 4'h0);
			homeReq <= {3'h7, 3'h7};
			@(posedge clk_sys);
			homeReq <= {s, 3'h0};
			@(posedge clk_sys);
			homeReq <= {3'h0, s};
			@(posedge clk_sys);
			homeReq <= {~s, ~s}; // every other source
			@(posedge clk_sys);
			idle();
			expectCount(32'h2);
		end
	endtask : testRequests
	task automatic testTrackers();
		logic [7:0] pat [4] = '{8'hc5, 8'h43, 8'h80, 8'hff};
		logic [31:0] exp [3] = '{32'h3, 32'h3, 32'h47};
		uncore_home_event_pkg::tracker_s [2:0] v;
		for (int c = 0; c < 3; c++) begin
			for (int t = 0; t < 3; t++) begin
				arm(8'h21 + c[7:0], 8'h01 << t, 4'h0);
				for (int k = 0; k < 4; k++) begin
					v = {3{8'hc7}};
					v[t] = pat[k];
					tracker <= v;
					@(posedge clk_sys);
				end
				idle();
				expectCount(exp[c]);
			end
		end
	endtask : testTrackers
	task automatic testConflict();
		// open 0,1,2; entry 1 reaches three conflicts, entry 0 two; stray close of 5; then close 0,1,2
		logic [17:0] ops [9] = '{18'h20400, 18'h24800, 18'h28c90, 18'h0009d, 18'h00080,
			18'h0, 18'h00008, 18'h00009, 18'h0000a};
		arm(8'h24, 8'h02, 4'h0);
		for (int k = 0; k < 9; k++) begin
			conflictOp <= ops[k];
			@(posedge clk_sys);
			if (k == 5) begin
				bus(1'b0, uncore_home_event_pkg::ADDR_COUNT_LO, 32'h0);
				chk(rd, 32'h0);
				bus(1'b0, uncore_home_event_pkg::ADDR_STATUS, 32'h0);
				chk(rd, 32'h301);
			end
		end
		idle();
		expectCount(32'h2);
	endtask : testConflict
	task automatic testUndefined();
		logic [19:0] sel [6] = '{20'h2080c, 20'h0080c, 20'h00320, 20'h00821, 20'h00125, 20'h00424};
		foreach (sel[i]) begin
			arm(sel[i][7:0], sel[i][15:8], sel[i][19:16]);
			snoop <= {2'h3, 4'hf};
			homeReq <= '1;
			tracker <= '1;
			conflictOp <= {1'b1, 3'h3, 6'h09, 8'h0};
			@(posedge clk_sys);
			conflictOp <= {14'h0, 1'b1, 3'h3};
			@(posedge clk_sys);
			idle();
			expectCount(32'h0);
		end
	endtask : testUndefined
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		testRegs();
		$display("test registers done");
		testSnoop();
		$display("test snoop done");
		testRequests();
		$display("test requests done");
		testTrackers();
		$display("test trackers done");
		testConflict();
		$display("test conflict done");
		testUndefined();
		$display("test undefined done");
		give_verdict();
	end
endmodule : tb_uncore_home_event_counter

bind uncore_home_event_counter uncore_home_event_counter_properties u_props (.clk_sys(clk_sys), .reset(reset),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

`default_nettype wire
